// ### verilog/spc_consts.vh
// Constants shared by the path counter and pointer generator design files.
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index).
// ****************************************************************
`define SPC_IDX_LOAD_METERS 10'h000
`define SPC_IDX_MASTER_CTRL 10'h001
`define SPC_IDX_PAR_LOW 10'h038
`define SPC_IDX_PAR_HIGH 10'h039
`define SPC_IDX_FAR_LOW 10'h03A
`define SPC_IDX_FAR_HIGH 10'h03B
`define SPC_IDX_PAR_CFG 10'h03D
`define SPC_IDX_DIAG_CTRL 10'h040
`define SPC_IDX_PTR_CTRL 10'h041
`define SPC_IDX_ARBITRARY_POINTER_LOW 10'h045
`define SPC_IDX_ARBITRARY_POINTER_HIGH 10'h046

// ****************************************************************
// Field positions.
// ****************************************************************
`define SPC_BIT_FIXED_PTR 0
`define SPC_BIT_BLOCK_MODE 5
`define SPC_BIT_ALARM 0
`define SPC_BIT_CORRUPT 1
`define SPC_BIT_POS_JUST 1
`define SPC_BIT_NEG_JUST 2
`define SPC_BIT_NDF_EN 3
`define SPC_BIT_PTR_LOAD 4
`define SPC_BIT_SPACING 5
`define SPC_BIT_FORCE 6

// ****************************************************************
// Masks of writable bits and reset values.
// ****************************************************************
`define SPC_MASK_PAR_CFG 8'hF7
`define SPC_MASK_DIAG 8'h07
`define SPC_MASK_PTR_CTRL 8'h7F
`define SPC_RST_PAR_CFG 8'h00
`define SPC_RST_DIAG 8'h00
`define SPC_RST_PTR_CTRL 8'h00
`define SPC_RST_ARBITRARY_POINTER_LOW 8'h00
`define SPC_RST_ARBITRARY_POINTER_HIGH 8'h90
`define SPC_RST_MASTER 8'h00

// ****************************************************************
// Pointer constants and timing counts.
// ****************************************************************
`define SPC_PTR_MAX 10'd782
`define SPC_NORMAL_NDF 4'h6
`define SPC_I_BITS 10'h2AA
`define SPC_D_BITS 10'h155
`define SPC_STUFF_GAP 3'd4
`define SPC_FEBE_MAX 4'd8

`endif

// ### verilog/spc_err_counter.v
// Error event accumulator with loss-free latch and restart.
`include "spc_consts.vh"

// ****************************************************************
// Accumulator module.
// ****************************************************************
module spc_err_counter (
	input wire clk_i,
	input wire reset_n_i,
	input wire [3:0] inc_i,
	input wire latch_i,
	output wire [15:0] latched_o
);

	reg [15:0] acc_r; // Running count of the current interval.
	reg [15:0] acc_nxt; // Next running count.
	reg [15:0] latched_r; // Value shown to software.
	reg [16:0] sum; // Widened sum used for saturation.

	// Sums the arriving events; on a latch the events of this very cycle go
	// into the closing interval, so nothing that coincides with a poll is lost.
	always @* begin
		sum = {1'b0, acc_r} + {13'h0000, inc_i};
		if (sum[16]) begin
			// Saturate rather than wrap so that a long interval never reads small.
			acc_nxt = 16'hFFFF;
		end else begin
			acc_nxt = sum[15:0];
		end
	end

	// Holds the count and performs the latch-and-clear.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_r <= 16'h0000;
			latched_r <= 16'h0000;
		end else if (latch_i) begin
			latched_r <= acc_nxt;
			acc_r <= 16'h0000;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	assign latched_o = latched_r;

endmodule // spc_err_counter

// ### verilog/spc_ptr_gen.v
// Path error counters and transmit pointer generator with an APB slave.
`include "spc_consts.vh"

// Overview of operation
// - Sixteen-bit path parity error count, two bytes.
// - Poll write latches count and restarts from zero.
// - Events in the poll cycle are never lost.
// - Sixteen-bit far-end error count, same polling.
// - Load-meters write also latches both counters.
// - Block mode counts one error per bad frame.
// - Alarm insert sends all ones payload and pointer.
// - Corrupt bit sends inverted path parity byte.
// - Rising request gives one positive justification, self-clears.
// - Rising request gives one negative justification, self-clears.
// - Fixed pointer setting blocks justifications and loads.
// - Flag enable sends programmed flags, else 0110.
// - Load moves pointer if value at most 782.
// - Pointer load bit clears itself once used.
// - Spacing bit keeps justifications four frames apart.
// - Force bit sends arbitrary value in pointer bytes.
// - Arbitrary pointer is low byte plus two bits.
// - Size bits go into every pointer sent outside alarm.
// - Programmed flags sent on load or flag enable.
module spc_ptr_gen (
	input wire clk_i,
	input wire reset_n_i,
	// APB slave.
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output wire [31:0] prdata_o,
	output wire pslverr_o,
	// Receive path overhead results, one pulse per frame each.
	input wire rx_parity_valid_i,
	input wire [7:0] rx_parity_mismatch_i,
	input wire rx_far_valid_i,
	input wire [3:0] rx_far_err_i,
	output wire [3:0] parity_report_o,
	output wire parity_report_valid_o,
	// Transmit stream.
	input wire tx_ptr_slot_i,
	input wire [7:0] tx_spe_byte_i,
	input wire [7:0] tx_parity_calc_i,
	output wire [7:0] tx_spe_byte_o,
	output wire [7:0] tx_parity_o,
	output wire [7:0] tx_h1_o,
	output wire [7:0] tx_h2_o,
	output wire [7:0] tx_h3_o,
	output wire tx_ptr_valid_o,
	output wire tx_pos_just_o,
	output wire tx_neg_just_o,
	output wire [9:0] tx_pointer_o
);

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Counts the set bits of a parity mismatch byte.
	function [3:0] spc_popcount;
		input [7:0] v;
		integer k;
		begin
			spc_popcount = 4'h0;
			for (k = 0; k < 8; k = k + 1) begin
				spc_popcount = spc_popcount + {3'b000, v[k]};
			end
		end
	endfunction

	// Selects the bits of a register that software may write.
	function [7:0] spc_merge;
		input [7:0] data;
		input [7:0] mask;
		begin
			spc_merge = data & mask;
		end
	endfunction

	// ****************************************************************
	// APB slave.
	// ****************************************************************

	reg pready_r; // Answer strobe, one wait state after the setup cycle.
	reg [31:0] prdata_r; // Registered read data.
	reg pslverr_r; // Registered error for unmapped addresses.
	reg [31:0] rd_nxt; // Read data for the current address.
	reg map_hit; // Address names a register.
	wire [9:0] idx; // Register index.
	wire wr_en; // Write takes effect at this edge.

	reg [7:0] master_r; // Chip master control.
	reg [7:0] par_cfg_r; // Path parity configuration.
	reg [7:0] diag_r; // Transmit diagnostic control.
	reg [7:0] ptr_ctrl_r; // Transmit pointer control.
	reg [7:0] ptr_ctrl_nxt; // Next pointer control.
	reg [7:0] arbitrary_pointer_low_r; // Arbitrary pointer low byte.
	reg [7:0] arbitrary_pointer_high_r; // Flags, size bits and pointer top bits.
	wire [15:0] par_count; // Latched parity count.
	wire [15:0] far_count; // Latched far-end count.

	assign idx = paddr_i[11:2];
	// The write lands only at the edge at which the master sees pready high.
	assign wr_en = psel_i & penable_i & pready_r & pwrite_i & map_hit;

	// Decodes the address and forms read data; byte offsets off a word fail.
	always @* begin
		map_hit = (paddr_i[1:0] == 2'b00);
		rd_nxt = 32'h0000_0000;
		case (idx)
			`SPC_IDX_LOAD_METERS: rd_nxt = 32'h0000_0000;
			`SPC_IDX_MASTER_CTRL: rd_nxt = {24'h000000, master_r};
			`SPC_IDX_PAR_LOW: rd_nxt = {24'h000000, par_count[7:0]};
			`SPC_IDX_PAR_HIGH: rd_nxt = {24'h000000, par_count[15:8]};
			`SPC_IDX_FAR_LOW: rd_nxt = {24'h000000, far_count[7:0]};
			`SPC_IDX_FAR_HIGH: rd_nxt = {24'h000000, far_count[15:8]};
			`SPC_IDX_PAR_CFG: rd_nxt = {24'h000000, par_cfg_r};
			`SPC_IDX_DIAG_CTRL: rd_nxt = {24'h000000, diag_r};
			`SPC_IDX_PTR_CTRL: rd_nxt = {24'h000000, ptr_ctrl_r};
			`SPC_IDX_ARBITRARY_POINTER_LOW: rd_nxt = {24'h000000, arbitrary_pointer_low_r};
			`SPC_IDX_ARBITRARY_POINTER_HIGH: rd_nxt = {24'h000000, arbitrary_pointer_high_r};
			default: map_hit = 1'b0;
		endcase
	end

	// Raises pready in the second access cycle and captures the answer.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (psel_i & penable_i & ~pready_r) begin
			pready_r <= 1'b1;
			prdata_r <= pwrite_i ? 32'h0000_0000 : (map_hit ? rd_nxt : 32'h0000_0000);
			pslverr_r <= ~map_hit;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	assign pready_o = pready_r;
	assign prdata_o = prdata_r;
	assign pslverr_o = pslverr_r;

	// ****************************************************************
	// Plain configuration registers.
	// ****************************************************************

	// Stores the software-owned registers; reserved bits are cleared, except in the two arbitrary pointer bytes.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			master_r <= `SPC_RST_MASTER;
			par_cfg_r <= `SPC_RST_PAR_CFG;
			diag_r <= `SPC_RST_DIAG;
			arbitrary_pointer_low_r <= `SPC_RST_ARBITRARY_POINTER_LOW;
			arbitrary_pointer_high_r <= `SPC_RST_ARBITRARY_POINTER_HIGH;
		end else if (wr_en) begin
			if (idx == `SPC_IDX_MASTER_CTRL) begin
				master_r <= spc_merge(pwdata_i[7:0], 8'h01);
			end
			if (idx == `SPC_IDX_PAR_CFG) begin
				par_cfg_r <= spc_merge(pwdata_i[7:0], `SPC_MASK_PAR_CFG);
			end
			if (idx == `SPC_IDX_DIAG_CTRL) begin
				diag_r <= spc_merge(pwdata_i[7:0], `SPC_MASK_DIAG);
			end
			if (idx == `SPC_IDX_ARBITRARY_POINTER_LOW) begin
				arbitrary_pointer_low_r <= pwdata_i[7:0];
			end
			if (idx == `SPC_IDX_ARBITRARY_POINTER_HIGH) begin
				arbitrary_pointer_high_r <= pwdata_i[7:0];
			end
		end
	end

	// ****************************************************************
	// Receive error counting.
	// ****************************************************************

	wire poll; // Latch-and-restart strobe for both counters.
	wire block_mode; // One error per bad frame when set.
	reg [3:0] par_inc; // Parity errors arriving this cycle.
	reg [3:0] far_inc; // Far-end errors arriving this cycle.
	reg [3:0] report_r; // Parity errors reported to the transmit side.
	reg report_valid_r; // Report strobe.

	// Any write to the four count addresses or to the load-meters address polls.
	assign poll = wr_en & ((idx == `SPC_IDX_PAR_LOW) | (idx == `SPC_IDX_PAR_HIGH) |
		(idx == `SPC_IDX_FAR_LOW) | (idx == `SPC_IDX_FAR_HIGH) |
		(idx == `SPC_IDX_LOAD_METERS));
	assign block_mode = par_cfg_r[`SPC_BIT_BLOCK_MODE];

	// Converts frame results into counts; far-end codes above eight mean none.
	always @* begin
		par_inc = 4'h0;
		far_inc = 4'h0;
		if (rx_parity_valid_i) begin
			if (block_mode) begin
				par_inc = {3'b000, |rx_parity_mismatch_i};
			end else begin
				par_inc = spc_popcount(rx_parity_mismatch_i);
			end
		end
		if (rx_far_valid_i && (rx_far_err_i <= `SPC_FEBE_MAX)) begin
			far_inc = rx_far_err_i;
		end
	end

	// Carries the same per-frame parity result to the transmit side.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			report_r <= 4'h0;
			report_valid_r <= 1'b0;
		end else begin
			report_valid_r <= rx_parity_valid_i;
			if (rx_parity_valid_i) begin
				report_r <= par_inc;
			end
		end
	end

	assign parity_report_o = report_r;
	assign parity_report_valid_o = report_valid_r;

	spc_err_counter u_par_cnt (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.inc_i(par_inc),
		.latch_i(poll),
		.latched_o(par_count)
	);

	spc_err_counter u_far_cnt (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.inc_i(far_inc),
		.latch_i(poll),
		.latched_o(far_count)
	);

	// ****************************************************************
	// Pointer control register and pointer generation.
	// ****************************************************************

	wire fixed; // Chip-level fixed pointer setting.
	wire alarm; // Path alarm insertion.
	wire [9:0] arbitrary_pointer; // Arbitrary pointer value.
	reg [9:0] ptr_r; // Current payload pointer.
	reg [9:0] ptr_nxt; // Pointer after this slot.
	reg [2:0] gap_r; // Pointer slots since the last justification.
	reg [9:0] word; // Pointer value bits sent in this slot.
	reg [3:0] flags; // Flag bits sent in this slot.
	reg do_pos; // Positive justification in this slot.
	reg do_neg; // Negative justification in this slot.
	reg do_load; // Load consumed in this slot.
	reg stuff_ok; // Spacing allows a justification.
	reg [7:0] h1_r; // Sent H1 byte.
	reg [7:0] h2_r; // Sent H2 byte.
	reg [7:0] h3_r; // Sent H3 byte.
	reg slot_r; // Pointer bytes valid strobe.
	reg pos_r; // Positive justification strobe.
	reg neg_r; // Negative justification strobe.
	reg [7:0] spe_r; // Sent payload byte.
	reg [7:0] b3_r; // Sent path parity byte.
	wire ctrl_wr; // Software writes the pointer control register.
	reg [7:0] old_bits; // Request bits as seen before this write.

	assign fixed = master_r[`SPC_BIT_FIXED_PTR];
	assign alarm = diag_r[`SPC_BIT_ALARM];
	assign arbitrary_pointer = {arbitrary_pointer_high_r[1:0], arbitrary_pointer_low_r};
	assign ctrl_wr = wr_en & (idx == `SPC_IDX_PTR_CTRL);

	// Chooses what this pointer slot does; load wins over positive over negative.
	always @* begin
		stuff_ok = ~ptr_ctrl_r[`SPC_BIT_SPACING] | (gap_r >= `SPC_STUFF_GAP);
		do_load = 1'b0;
		do_pos = 1'b0;
		do_neg = 1'b0;
		ptr_nxt = ptr_r;
		if (tx_ptr_slot_i && !alarm && !fixed) begin
			if (ptr_ctrl_r[`SPC_BIT_PTR_LOAD]) begin
				do_load = 1'b1;
				if (arbitrary_pointer <= `SPC_PTR_MAX) begin
					ptr_nxt = arbitrary_pointer;
				end
			end else if (ptr_ctrl_r[`SPC_BIT_POS_JUST] && stuff_ok) begin
				do_pos = 1'b1;
				ptr_nxt = (ptr_r == `SPC_PTR_MAX) ? 10'd0 : ptr_r + 10'd1;
			end else if (ptr_ctrl_r[`SPC_BIT_NEG_JUST] && stuff_ok) begin
				do_neg = 1'b1;
				ptr_nxt = (ptr_r == 10'd0) ? `SPC_PTR_MAX : ptr_r - 10'd1;
			end
		end
		// A loaded pointer goes out at once with the programmed flags.
		if (ptr_ctrl_r[`SPC_BIT_NDF_EN] || do_load) begin
			flags = arbitrary_pointer_high_r[7:4];
		end else begin
			flags = `SPC_NORMAL_NDF;
		end
		if (ptr_ctrl_r[`SPC_BIT_FORCE]) begin
			// The forced value is sent unchecked, which corrupts the pointer.
			word = arbitrary_pointer;
		end else if (do_load) begin
			word = ptr_nxt;
		end else if (do_pos) begin
			word = ptr_r ^ `SPC_I_BITS;
		end else if (do_neg) begin
			word = ptr_r ^ `SPC_D_BITS;
		end else begin
			word = ptr_r;
		end
	end

	// Updates the pointer control bits; the self-clears of the request bits
	// are overridden by a write in the same cycle, and such a write counts as
	// a fresh rising edge so that no request is lost.
	always @* begin
		ptr_ctrl_nxt = ptr_ctrl_r;
		old_bits = ptr_ctrl_r;
		if (do_pos) begin
			ptr_ctrl_nxt[`SPC_BIT_POS_JUST] = 1'b0;
			old_bits[`SPC_BIT_POS_JUST] = 1'b0;
		end
		if (do_neg) begin
			ptr_ctrl_nxt[`SPC_BIT_NEG_JUST] = 1'b0;
			old_bits[`SPC_BIT_NEG_JUST] = 1'b0;
		end
		if (do_load) begin
			ptr_ctrl_nxt[`SPC_BIT_PTR_LOAD] = 1'b0;
			old_bits[`SPC_BIT_PTR_LOAD] = 1'b0;
		end
		if (ctrl_wr) begin
			ptr_ctrl_nxt = spc_merge(pwdata_i[7:0], `SPC_MASK_PTR_CTRL);
			// A request bit takes the written value: a one arms it or keeps it pending, a zero cancels it.
			ptr_ctrl_nxt[`SPC_BIT_POS_JUST] = pwdata_i[`SPC_BIT_POS_JUST] &
				(~old_bits[`SPC_BIT_POS_JUST] | ptr_ctrl_nxt[`SPC_BIT_POS_JUST]);
			ptr_ctrl_nxt[`SPC_BIT_NEG_JUST] = pwdata_i[`SPC_BIT_NEG_JUST] &
				(~old_bits[`SPC_BIT_NEG_JUST] | ptr_ctrl_nxt[`SPC_BIT_NEG_JUST]);
			// With the fixed pointer set, requests and loads are not armed.
			if (fixed) begin
				ptr_ctrl_nxt[`SPC_BIT_POS_JUST] = 1'b0;
				ptr_ctrl_nxt[`SPC_BIT_NEG_JUST] = 1'b0;
				ptr_ctrl_nxt[`SPC_BIT_PTR_LOAD] = 1'b0;
			end
		end
	end

	// Holds pointer state and the outgoing pointer bytes.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ptr_ctrl_r <= `SPC_RST_PTR_CTRL;
			ptr_r <= 10'd0;
			gap_r <= 3'd0;
			h1_r <= 8'h00;
			h2_r <= 8'h00;
			h3_r <= 8'h00;
			slot_r <= 1'b0;
			pos_r <= 1'b0;
			neg_r <= 1'b0;
		end else begin
			ptr_ctrl_r <= ptr_ctrl_nxt;
			slot_r <= tx_ptr_slot_i;
			pos_r <= do_pos;
			neg_r <= do_neg;
			if (tx_ptr_slot_i) begin
				ptr_r <= ptr_nxt;
				if (do_pos | do_neg) begin
					gap_r <= 3'd1;
				end else if (gap_r < `SPC_STUFF_GAP) begin
					gap_r <= gap_r + 3'd1;
				end
				if (alarm) begin
					h1_r <= 8'hFF;
					h2_r <= 8'hFF;
					h3_r <= 8'hFF;
				end else begin
					h1_r <= {flags, arbitrary_pointer_high_r[3:2], word[9:8]};
					h2_r <= word[7:0];
					h3_r <= 8'h00;
				end
			end
		end
	end

	// Passes payload and path parity, forcing ones or inverting as asked.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			spe_r <= 8'h00;
			b3_r <= 8'h00;
		end else begin
			spe_r <= alarm ? 8'hFF : tx_spe_byte_i;
			if (alarm) begin
				b3_r <= 8'hFF;
			end else if (diag_r[`SPC_BIT_CORRUPT]) begin
				b3_r <= ~tx_parity_calc_i;
			end else begin
				b3_r <= tx_parity_calc_i;
			end
		end
	end

	assign tx_spe_byte_o = spe_r;
	assign tx_parity_o = b3_r;
	assign tx_h1_o = h1_r;
	assign tx_h2_o = h2_r;
	assign tx_h3_o = h3_r;
	assign tx_ptr_valid_o = slot_r;
	assign tx_pos_just_o = pos_r;
	assign tx_neg_just_o = neg_r;
	assign tx_pointer_o = ptr_r;

endmodule // spc_ptr_gen

// ### sim/spc_ptr_gen_properties.sv
// Concurrent checks on the ports of the pointer generator.
module spc_chk (
	input wire clk_i,
	input wire reset_n_i,
	input wire rx_parity_valid_i,
	input wire parity_report_valid_o,
	input wire tx_ptr_slot_i,
	input wire tx_ptr_valid_o,
	input wire tx_pos_just_o,
	input wire tx_neg_just_o,
	input wire [7:0] tx_h1_o,
	input wire [9:0] tx_pointer_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************************
	// Clocking and shared sequences.
	// ****************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// A pointer slot is answered by the valid strobe on the next edge.
	sequence s_slot_answer;
		##1 tx_ptr_valid_o;
	endsequence
	// A justification pulse rides on the pointer strobe, never both kinds at once.
	sequence s_just_alone;
		tx_ptr_valid_o && !(tx_pos_just_o && tx_neg_just_o);
	endsequence
	// ****************************************************************
	// Assertions.
	// ****************************************************************
	a_report_follows: assert property (rx_parity_valid_i |=> parity_report_valid_o)
		else $error("parity report missing after a frame result");
	a_report_cause: assert property (parity_report_valid_o |-> $past(rx_parity_valid_i))
		else $error("parity report without a frame result");
	a_slot_answer: assert property (tx_ptr_slot_i |-> s_slot_answer)
		else $error("pointer slot not answered");
	a_valid_cause: assert property (tx_ptr_valid_o |-> $past(tx_ptr_slot_i))
		else $error("pointer strobe without a slot");
	a_just_aligned: assert property ((tx_pos_just_o || tx_neg_just_o) |-> s_just_alone)
		else $error("justification pulse misplaced");
	a_pos_step: assert property (tx_pos_just_o |-> tx_pointer_o == (($past(tx_pointer_o)
		== 10'h30E) ? 10'h000 : $past(tx_pointer_o) + 10'h001))
		else $error("positive justification did not advance the pointer");
	a_neg_step: assert property (tx_neg_just_o |-> tx_pointer_o == (($past(tx_pointer_o)
		== 10'h000) ? 10'h30E : $past(tx_pointer_o) - 10'h001))
		else $error("negative justification did not retard the pointer");
	a_bytes_hold: assert property (!tx_ptr_valid_o |-> $stable(tx_h1_o)
		&& $stable(tx_pointer_o))
		else $error("pointer changed outside a slot");
	a_ptr_legal: assert property (tx_pointer_o <= 10'h30E)
		else $error("pointer beyond the last byte position");
endmodule // spc_chk

bind spc_ptr_gen spc_chk spc_chk_i (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.rx_parity_valid_i(rx_parity_valid_i),
	.parity_report_valid_o(parity_report_valid_o),
	.tx_ptr_slot_i(tx_ptr_slot_i),
	.tx_ptr_valid_o(tx_ptr_valid_o),
	.tx_pos_just_o(tx_pos_just_o),
	.tx_neg_just_o(tx_neg_just_o),
	.tx_h1_o(tx_h1_o),
	.tx_pointer_o(tx_pointer_o)
);

// ### sim/spc_line_model.sv
// Line-side frame source: slot strobe, payload bytes and computed parity.
module spc_line_model #(
	parameter int FRAME = 20
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	output logic tx_ptr_slot_o,
	output logic [7:0] tx_spe_byte_o,
	output logic [7:0] tx_parity_calc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt; // Position within the shortened frame.
	// Payload and parity change every cycle so a stuck output cannot pass.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt <= 0;
			tx_ptr_slot_o <= 1'b0;
			tx_spe_byte_o <= 8'h00;
			tx_parity_calc_o <= 8'h00;
		end else begin
			cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
			tx_ptr_slot_o <= (cnt == FRAME - 1);
			tx_spe_byte_o <= tx_spe_byte_o + 8'h01;
			tx_parity_calc_o <= {tx_spe_byte_o[3:0], 4'h5};
		end
	end
endmodule // spc_line_model

// ### sim/testbench.sv
// Self-checking bench for the path counters and pointer generator.
`include "spc_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic rxp_v = 1'b0, rxf_v = 1'b0;
	logic [7:0] rxp_m = 8'h00;
	logic [3:0] rxf_e = 4'h0;
	wire pready, pslverr, slot, rep_v, pv, pj, nj;
	wire [31:0] prdata;
	wire [3:0] rep;
	wire [7:0] spe_in, calc, spe, par, h1, h2, h3;
	wire [9:0] ptr;
	int err_count = 0, n_compared = 0, k;
	logic [7:0] v, c;
	logic e;
	always #25 clk = ~clk;
	spc_ptr_gen spc_ptr_gen_i (.clk_i(clk), .reset_n_i(reset_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.rx_parity_valid_i(rxp_v), .rx_parity_mismatch_i(rxp_m), .rx_far_valid_i(rxf_v),
		.rx_far_err_i(rxf_e), .parity_report_o(rep), .parity_report_valid_o(rep_v),
		.tx_ptr_slot_i(slot), .tx_spe_byte_i(spe_in), .tx_parity_calc_i(calc),
		.tx_spe_byte_o(spe), .tx_parity_o(par), .tx_h1_o(h1), .tx_h2_o(h2), .tx_h3_o(h3),
		.tx_ptr_valid_o(pv), .tx_pos_just_o(pj), .tx_neg_just_o(nj), .tx_pointer_o(ptr));
	spc_line_model spc_line_model_i (.clk_i(clk), .reset_n_i(reset_n),
		.tx_ptr_slot_o(slot), .tx_spe_byte_o(spe_in), .tx_parity_calc_o(calc));
	// ****************************************************************
	// Closing report and bus tasks.
	// ****************************************************************
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// A wait that runs out of its bound is a failure in its own right.
	task automatic fail_wait();
		err_count++;
		complete_run();
	endtask
	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		v = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) fail_wait();
	endtask
	task automatic rd(input logic [9:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	// Waits for the pointer strobe; outputs read here belong to that slot.
	task automatic wslot();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pv !== 1'b1 && n < 100);
		if (n >= 100) fail_wait();
	endtask
	// Control writes follow a slot so they never race the next one.
	task automatic wctl(input logic [7:0] d);
		wslot();
		apb(1'b1, `SPC_IDX_PTR_CTRL, d);
	endtask
	task automatic rxev(input logic [7:0] m, input logic [3:0] f);
		@(posedge clk);
		rxp_v <= 1'b1;
		rxp_m <= m;
		rxf_v <= 1'b1;
		rxf_e <= f;
		@(posedge clk);
		rxp_v <= 1'b0;
		rxf_v <= 1'b0;
		@(posedge clk);
	endtask
	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_regs();
		rd(`SPC_IDX_ARBITRARY_POINTER_HIGH);
		`CHK(v, 8'h90)
		rd(`SPC_IDX_PTR_CTRL);
		`CHK(v, 8'h00)
		rd(10'h03C);
		`CHK(e, 1'b1)
		$display("register test done");
	endtask
	// Bit mode, polls through several addresses, then block mode.
	task automatic t_count();
		rxev(8'h03, 4'h5);
		`CHK(rep, 4'h2)
		rxev(8'h80, 4'h8);
		apb(1'b1, `SPC_IDX_PAR_HIGH, 8'h00);
		rd(`SPC_IDX_PAR_LOW);
		`CHK(v, 8'h03)
		rd(`SPC_IDX_PAR_HIGH);
		`CHK(v, 8'h00)
		rd(`SPC_IDX_FAR_LOW);
		`CHK(v, 8'h0D)
		apb(1'b1, `SPC_IDX_FAR_LOW, 8'h00);
		rd(`SPC_IDX_PAR_LOW);
		`CHK(v, 8'h00)
		apb(1'b1, `SPC_IDX_PAR_CFG, 8'h20);
		rxev(8'hFF, 4'h0);
		`CHK(rep, 4'h1)
		rxev(8'h01, 4'h3);
		apb(1'b1, `SPC_IDX_LOAD_METERS, 8'h00);
		rd(`SPC_IDX_PAR_LOW);
		`CHK(v, 8'h02)
		rd(`SPC_IDX_FAR_LOW);
		`CHK(v, 8'h03)
		// A frame result on the very poll edge belongs to the closing interval.
		fork
			apb(1'b1, `SPC_IDX_PAR_LOW, 8'h00);
			begin
				repeat (3) @(posedge clk);
				rxp_v <= 1'b1;
				@(posedge clk);
				rxp_v <= 1'b0;
			end
		join
		rd(`SPC_IDX_PAR_LOW);
		`CHK(v, 8'h01)
		apb(1'b1, `SPC_IDX_PAR_LOW, 8'h00);
		rd(`SPC_IDX_PAR_LOW);
		`CHK(v, 8'h00)
		apb(1'b1, `SPC_IDX_PAR_CFG, 8'h00);
		$display("count test done");
	endtask
	// Legal load, illegal load, then one step each way.
	task automatic t_move();
		apb(1'b1, `SPC_IDX_ARBITRARY_POINTER_LOW, 8'hF4);
		apb(1'b1, `SPC_IDX_ARBITRARY_POINTER_HIGH, 8'h99);
		wctl(8'h10);
		wslot();
		`CHK(ptr, 10'h1F4)
		`CHK(h1, 8'h99)
		`CHK(h3, 8'h00)
		rd(`SPC_IDX_PTR_CTRL);
		`CHK(v, 8'h00)
		apb(1'b1, `SPC_IDX_ARBITRARY_POINTER_LOW, 8'hFF);
		apb(1'b1, `SPC_IDX_ARBITRARY_POINTER_HIGH, 8'h9B);
		wctl(8'h10);
		wslot();
		`CHK(ptr, 10'h1F4)
		wctl(8'h02);
		wslot();
		`CHK(pj, 1'b1)
		`CHK(ptr, 10'h1F5)
		wctl(8'h04);
		wslot();
		`CHK(nj, 1'b1)
		`CHK(h1[7:2], 6'h1A)
		rd(`SPC_IDX_PTR_CTRL);
		`CHK(v, 8'h00)
		$display("pointer move test done");
	endtask
	// With spacing on, the second stuff waits at least four slots.
	task automatic t_space();
		// The stuff of the previous test must age four slots before the next one.
		repeat (2) wslot();
		wctl(8'h22);
		wslot();
		`CHK(pj, 1'b1)
		wctl(8'h24);
		k = 1;
		do begin
			wslot();
			k++;
		end while (nj !== 1'b1 && k < 9);
		`CHK(nj, 1'b1)
		`CHK(k >= 4, 1'b1)
		`CHK(ptr, 10'h1F4)
		wctl(8'h00);
		$display("spacing test done");
	endtask
	task automatic t_fixed();
		apb(1'b1, `SPC_IDX_MASTER_CTRL, 8'h01);
		wctl(8'h12);
		wslot();
		wslot();
		`CHK(ptr, 10'h1F4)
		apb(1'b1, `SPC_IDX_MASTER_CTRL, 8'h00);
		wctl(8'h08);
		wslot();
		`CHK(h1[7:4], 4'h9)
		wctl(8'h40);
		wslot();
		`CHK({h1[1:0], h2}, 10'h3FF)
		`CHK(ptr, 10'h1F4)
		wctl(8'h00);
		$display("fixed and forced pointer test done");
	endtask
	// Alarm fills everything with ones; corruption inverts parity.
	task automatic t_diag();
		apb(1'b1, `SPC_IDX_DIAG_CTRL, 8'h01);
		wslot();
		`CHK({h1, h2, h3, spe}, 32'hFFFFFFFF)
		apb(1'b1, `SPC_IDX_DIAG_CTRL, 8'h02);
		@(posedge clk);
		c = calc;
		@(posedge clk);
		`CHK(par, ~c)
		apb(1'b1, `SPC_IDX_DIAG_CTRL, 8'h00);
		@(posedge clk);
		c = calc;
		v = spe_in;
		@(posedge clk);
		`CHK(par, c)
		`CHK(spe, v)
		$display("diagnostic test done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_count();
		t_move();
		t_space();
		t_fixed();
		t_diag();
		complete_run();
	end
endmodule // testbench
